// [logic/line_pulse_pkg.sv]
// constants and carrier types for the output line pulse control block
// assumes a single 25 MHz clock and a plain strobe register port
package line_pulse_pkg;

  ////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int unsigned N_IN = 2;
  localparam int unsigned N_OUT = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLOCK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = (CLOCK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // register map: group in addr[7:4], output line index in addr[3:2]
  localparam logic [3:0] GRP_CONFIG = 4'h0;
  localparam logic [3:0] GRP_DELAY = 4'h1;
  localparam logic [3:0] GRP_WIDTH = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_MASK = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_SNAPSHOT = 8'h34;

  ////////////////////////////////////////////////////////////////////////
  // encodings
  typedef enum logic [1:0] {
    leading_transition = 2'h0,
    trailing_transition = 2'h1,
    either_transition = 2'h2
  } pulse_trigger_polarity_e;

  typedef enum logic [2:0] {
    origin_off = 3'h0,
    host_driven_origin = 3'h1,
    host_strobe_pulse_origin = 3'h2,
    pulse_on_input1_origin = 3'h3,
    pulse_on_input2_origin = 3'h4
  } drive_origin_select_e;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_delay = 3'b010,
    st_width = 3'b100
  } pulse_state_e;

  // config word layout, bit 0 upward: polarity, origin, deferred, level, dir
  typedef struct packed {
    logic direction_setting;
    logic static_level_setting;
    logic deferred_apply_control;
    drive_origin_select_e drive_origin_select;
    pulse_trigger_polarity_e pulse_trigger_polarity;
  } line_cfg_s;

  localparam int unsigned CFG_W = 8;
  localparam line_cfg_s CFG_RESET = '{
    direction_setting: 1'b0,
    static_level_setting: 1'b0,
    deferred_apply_control: 1'b0,
    drive_origin_select: origin_off,
    pulse_trigger_polarity: leading_transition
  };
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

endpackage

// [logic/output_line_pulse_control.sv]
// output line pulse control: pulse timing and static levels for lines 3..6
// assumes synchronous input pins and a strobe register port with one-cycle
// read latency
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module output_line_pulse_control
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // register port
  input wire logic [line_pulse_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  // lines
  input wire logic [line_pulse_pkg::N_IN-1:0] i_line_in,
  output logic [line_pulse_pkg::N_OUT-1:0] o_line_close
);

  localparam int unsigned NO = line_pulse_pkg::N_OUT;
  localparam int unsigned CW = line_pulse_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // microsecond tick
  logic [line_pulse_pkg::TICK_W-1:0] tick_cnt_reg;
  logic [line_pulse_pkg::TICK_W-1:0] tick_cnt_next;
  logic tick;

  always_comb
  begin
    tick = (tick_cnt_reg == line_pulse_pkg::TICK_LAST);
    if (tick)
    begin
      tick_cnt_next = '0;
    end
    else
    begin
      tick_cnt_next = tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tick_cnt_reg <= '0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file
  line_pulse_pkg::line_cfg_s cfg_reg [NO];
  line_pulse_pkg::line_cfg_s cfg_next [NO];
  logic [CW-1:0] delay_reg [NO];
  logic [CW-1:0] delay_next [NO];
  logic [CW-1:0] width_reg [NO];
  logic [CW-1:0] width_next [NO];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [NO-1:0] soft_hit;
  logic [NO-1:0] close_reg;
  logic [line_pulse_pkg::N_IN-1:0] in_prev_reg;
  logic [3:0] grp;
  logic [1:0] idx;

  assign grp = i_addr[7:4];
  assign idx = i_addr[3:2];

  always_comb
  begin
    for (int k = 0; k < NO; k++)
    begin
      cfg_next[k] = cfg_reg[k];
      delay_next[k] = delay_reg[k];
      width_next[k] = width_reg[k];
    end
    rdata_next = '0;
    soft_hit = '0;
    if (i_write)
    begin
      case (grp)
        line_pulse_pkg::GRP_CONFIG:
          cfg_next[idx] = i_wdata[line_pulse_pkg::CFG_W-1:0];
        line_pulse_pkg::GRP_DELAY:
          delay_next[idx] = i_wdata[CW-1:0];
        line_pulse_pkg::GRP_WIDTH:
          width_next[idx] = i_wdata[CW-1:0];
        default:
          if (i_addr == line_pulse_pkg::ADDR_SOFT_MASK)
          begin
            soft_hit = i_wdata[NO-1:0];
          end
      endcase
    end
    if (i_read)
    begin
      case (grp)
        line_pulse_pkg::GRP_CONFIG:
          rdata_next = {24'h000000, cfg_reg[idx]};
        line_pulse_pkg::GRP_DELAY:
          rdata_next = {16'h0000, delay_reg[idx]};
        line_pulse_pkg::GRP_WIDTH:
          rdata_next = {16'h0000, width_reg[idx]};
        default:
          if (i_addr == line_pulse_pkg::ADDR_SNAPSHOT)
          begin
            rdata_next = {26'h0000000, close_reg, i_line_in};
          end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int k = 0; k < NO; k++)
      begin
        cfg_reg[k] <= line_pulse_pkg::CFG_RESET;
        delay_reg[k] <= line_pulse_pkg::CNT_RESET;
        width_reg[k] <= line_pulse_pkg::CNT_RESET;
      end
      rdata_reg <= '0;
      in_prev_reg <= '0;
    end
    else
    begin
      for (int k = 0; k < NO; k++)
      begin
        cfg_reg[k] <= cfg_next[k];
        delay_reg[k] <= delay_next[k];
        width_reg[k] <= width_next[k];
      end
      rdata_reg <= rdata_next;
      in_prev_reg <= i_line_in;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_line_close = close_reg;

  ////////////////////////////////////////////////////////////////////////
  // per output line engine
  genvar g;
  generate
    for (g = 0; g < NO; g++)
    begin : gen_line
      line_pulse_pkg::pulse_state_e state_reg;
      line_pulse_pkg::pulse_state_e state_next;
      logic [CW-1:0] cnt_reg;
      logic [CW-1:0] cnt_next;
      logic applied_reg;
      logic applied_next;
      logic close_next;
      logic src_now;
      logic src_old;
      logic rise;
      logic fall;
      logic edge_ok;
      logic trig;
      line_pulse_pkg::line_cfg_s c;

      always_comb
      begin
        c = cfg_reg[g];
        src_now = (c.drive_origin_select ==
          line_pulse_pkg::pulse_on_input1_origin) ? i_line_in[0]
          : i_line_in[1];
        src_old = (c.drive_origin_select ==
          line_pulse_pkg::pulse_on_input1_origin) ? in_prev_reg[0]
          : in_prev_reg[1];
        rise = src_now & ~src_old;
        fall = ~src_now & src_old;
        case (c.pulse_trigger_polarity)
          line_pulse_pkg::leading_transition: edge_ok = rise;
          line_pulse_pkg::trailing_transition: edge_ok = fall;
          line_pulse_pkg::either_transition:
            edge_ok = rise | fall;
          default: edge_ok = 1'b0;
        endcase
        case (c.drive_origin_select)
          line_pulse_pkg::pulse_on_input1_origin,
          line_pulse_pkg::pulse_on_input2_origin:
            trig = edge_ok;
          line_pulse_pkg::host_strobe_pulse_origin:
            trig = soft_hit[g];
          default: trig = 1'b0;
        endcase

        applied_next = applied_reg;
        if (c.drive_origin_select == line_pulse_pkg::host_driven_origin)
        begin
          if (!c.deferred_apply_control)
          begin
            applied_next = c.static_level_setting;
          end
          else if (soft_hit[g])
          begin
            applied_next = c.static_level_setting;
          end
        end

        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
          line_pulse_pkg::st_idle:
            if (trig)
            begin
              cnt_next = '0;
              if (delay_reg[g] != '0)
              begin
                state_next = line_pulse_pkg::st_delay;
              end
              else if (width_reg[g] != '0)
              begin
                state_next = line_pulse_pkg::st_width;
              end
            end
          line_pulse_pkg::st_delay:
            if (tick)
            begin
              if (cnt_reg + 1'b1 == delay_reg[g])
              begin
                cnt_next = '0;
                state_next = (width_reg[g] != '0) ?
                  line_pulse_pkg::st_width : line_pulse_pkg::st_idle;
              end
              else
              begin
                cnt_next = cnt_reg + 1'b1;
              end
            end
          line_pulse_pkg::st_width:
            if (tick)
            begin
              if (cnt_reg + 1'b1 == width_reg[g])
              begin
                cnt_next = '0;
                state_next = line_pulse_pkg::st_idle;
              end
              else
              begin
                cnt_next = cnt_reg + 1'b1;
              end
            end
          default:
          begin
            state_next = line_pulse_pkg::st_idle;
            cnt_next = '0;
          end
        endcase

        // high means the output circuit is closed
        if (!c.direction_setting)
        begin
          close_next = 1'b0;
        end
        else if (c.drive_origin_select ==
          line_pulse_pkg::host_driven_origin)
        begin
          close_next = applied_next;
        end
        else
        begin
          close_next = (state_next == line_pulse_pkg::st_width);
        end
      end

      always_ff @(posedge i_clock or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          state_reg <= line_pulse_pkg::st_idle;
          cnt_reg <= '0;
          applied_reg <= 1'b0;
          close_reg[g] <= 1'b0;
        end
        else
        begin
          state_reg <= state_next;
          cnt_reg <= cnt_next;
          applied_reg <= applied_next;
          close_reg[g] <= close_next;
        end
      end
    end
  endgenerate

endmodule

// [verif/line_pulse_asserts.sv]
// port checker for the output line pulse control block
// assumes the register map of line_pulse_pkg and a single clock
`timescale 1ns/1ps
module line_pulse_asserts
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // register port
  input wire logic [line_pulse_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [31:0] o_rdata,
  // lines
  input wire logic [line_pulse_pkg::N_IN-1:0] i_line_in,
  input wire logic [line_pulse_pkg::N_OUT-1:0] o_line_close
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  //////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_snap_inputs: assert property ($past(i_read)
    && $past(i_addr) == 8'h34
    |-> o_rdata[1:0] == $past(i_line_in))
    else $error("snapshot input bits wrong");
  a_snap_outputs: assert property ($past(i_read)
    && $past(i_addr) == 8'h34
    |-> o_rdata[5:2] == $past(o_line_close))
    else $error("snapshot output bits wrong");
  a_snap_upper: assert property ($past(i_read)
    && $past(i_addr) == 8'h34
    |-> o_rdata[31:6] == 26'h0)
    else $error("snapshot upper bits not zero");
  a_mask_reads_zero: assert property ($past(i_read)
    && $past(i_addr) == 8'h30
    |-> o_rdata == 32'h0)
    else $error("command mask readable");
  a_unmapped_zero: assert property ($past(i_read)
    && $past(i_addr) == 8'h3c
    |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_static_level: assert property (i_write && i_addr == 8'h00
    && i_wdata[7] && i_wdata[5:2] == 4'h1
    |-> ##2 o_line_close[0] == $past(i_wdata[6], 2))
    else $error("static level not applied");
  a_dir_quiet: assert property (i_write && i_addr == 8'h00
    && !i_wdata[7]
    |-> ##2 !o_line_close[0])
    else $error("input-direction line driven");
endmodule
bind output_line_pulse_control line_pulse_asserts u_chk (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
  .o_rdata(o_rdata), .i_line_in(i_line_in), .o_line_close(o_line_close)
);

// [verif/strobe_lamp.sv]
// strobe lamp model hanging on the first output line
// assumes a closed circuit while the line is high; reports the last flash
`timescale 1ns/1ps
module strobe_lamp
(
  // clock
  input wire logic i_clock,
  // lines
  input wire logic [3:0] i_close,
  output int o_len
);
  int run = 0;
  // flash length in clock cycles, taken when the circuit opens
  always @(posedge i_clock)
  begin
    if (i_close[0])
      run <= run + 1;
    else if (run != 0)
    begin
      o_len <= run;
      run <= 0;
    end
  end
endmodule

// [verif/testbench.sv]
// self-checking bench for the output line pulse control block
// assumes a 25 MHz clock, delay 2 us and width 3 us for pulse runs
`timescale 1ns/1ps
module testbench;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [31:0] o_rdata;
  logic [1:0] i_line_in = 2'h0;
  logic [3:0] o_line_close;
  int pulse_len;
  int error_cnt = 0;
  int n_checks = 0;
  always #20 i_clock = ~i_clock;
  output_line_pulse_control u_dut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_line_in(i_line_in), .o_line_close(o_line_close)
  );
  strobe_lamp u_lamp (.i_clock(i_clock), .i_close(o_line_close),
    .o_len(pulse_len));
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    chk("rdata", e, o_rdata);
    @(posedge i_clock);
  endtask
  task automatic ck_close(input logic [3:0] e);
    @(posedge i_clock);
    #1;
    chk("close", 32'(e), 32'(o_line_close));
  endtask
  // waits for a pulse on line 3, then checks its delay and width
  task automatic watch(input bit fire, input int lo, input int hi);
    int c;
    c = 0;
    while (!o_line_close[0] && c < 120)
    begin
      @(posedge i_clock);
      c++;
    end
    chk("pulse seen", 32'(fire), 32'(o_line_close[0] === 1'b1));
    if (fire && c == 120)
      give_verdict();
    if (fire)
    begin
      chk("delay", 32'h1, 32'(c >= lo && c <= hi));
      repeat (100) @(posedge i_clock);
      // a width that follows a delay starts on a tick: exactly 3 us
      chk("width", 32'd75, 32'(pulse_len));
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    rd(8'h00, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h3c, 32'h0);
    for (int k = 0; k < 4; k++)
      wr(8'(k * 4), 32'hc4);
    ck_close(4'hf);
    rd(8'h34, 32'h3c);
    i_line_in <= 2'h2;
    rd(8'h34, 32'h3e);
    wr(8'h04, 32'h84);
    ck_close(4'hd);
    wr(8'h00, 32'h44);
    ck_close(4'hc);
    for (int k = 0; k < 4; k++)
      wr(8'(k * 4), 32'h84);
    ck_close(4'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'(k * 4), 32'he4);
      ck_close(4'((1 << k) - 1));
      wr(8'h30, 32'(1 << k));
      ck_close(4'((2 << k) - 1));
    end
    i_line_in <= 2'h0;
    wr(8'h10, 32'h2);
    wr(8'h20, 32'h3);
    rd(8'h10, 32'h2);
    rd(8'h20, 32'h3);
    wr(8'h00, 32'h8c);
    rd(8'h00, 32'h8c);
    wr(8'h30, 32'h1);
    watch(1'b0, 0, 0);
    for (int p = 0; p < 3; p++)
    begin
      wr(8'h00, 32'h8c | 32'(p));
      i_line_in[0] <= 1'b1;
      // 2 us delay lands 26 to 50 cycles after the edge, seen 2 later
      watch(p != 1, 28, 52);
      i_line_in[0] <= 1'b0;
      watch(p != 0, 28, 52);
    end
    wr(8'h00, 32'h88);
    wr(8'h30, 32'h1);
    watch(1'b1, 26, 50);
    wr(8'h00, 32'h90);
    i_line_in[1] <= 1'b1;
    watch(1'b1, 28, 52);
    give_verdict();
  end
endmodule
